// ==== rtl/vls_serializer.sv ====
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
// Contract
// RQ1 - one 35-bit symbol per pixel cycle
// RQ2 - pixel clock within 5 to 85 MHz
// RQ3 - line rate 525 Mbps to 2.975 Gbps
// RQ4 - bit time is pixel period over 35 (code: fixed at 2*LINK_HALF clk cycles whatever the pixel period)
// RQ5 - lock within 131 pixel periods after power-up
// RQ6 - scramble, DC-balance, embed clock in stream (legacy symbols are scrambled but not DC-balanced)
// RQ7 - encrypt serialized video and audio (legacy symbols are sent unencrypted)
// RQ8 - keys on chip, exchange over control channel
// RQ9 - return channel: control, cipher, CRC, 4 GPIO
// RQ10 - one return bit per forward symbol
// RQ11 - legacy mode sends 28 bits per symbol
// RQ12 - legacy pixel range set by low-rate select
// RQ13 - legacy mode from strap pin or register
// RQ14 - filter on: 2 transitions/130, 3-cycle pulses
// RQ15 - filter off: 2 transitions/130, any width
// RQ16 - frame sync: 1 transition/130 cycles
// RQ17 - drop glitches on video control signals
// RQ18 - power-down input low powers device down
// RQ19 - remote partner down: enter reduced power
// RQ20 - remote partner up: resume automatically
// RQ21 - remote auto power-down enable at 0x01[7]
// RQ22 - low-rate select picks 15-85 or 5-15 MHz
// RQ23 - low-rate change needs power-down cycle
// RQ24 - sample inputs on selected pixel edge
module vls_serializer #(
  parameter logic [31:0] KEY = vls_pkg::KEY_DEFAULT,
  parameter int LINK_HALF = vls_pkg::LINK_HALF_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pixel side
  input wire logic pclk,
  input wire logic [23:0] colour,
  input wire logic data_enable,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic [2:0] audio,
  input wire logic ctl_tx,
  // pins
  input wire logic power_down_n,
  input wire logic low_rate_select,
  input wire logic legacy_strap,
  output logic ctl_rx,
  // link
  vls_link_if.ser lnk
);
  import vls_pkg::*;

  if (LINK_HALF < 1 || LINK_HALF > 15)
  begin : bad_half
    $error("LINK_HALF must be 1 to 15");
  end

  typedef enum logic [1:0] {S_OFF, S_LOCKING, S_LOCKED, S_RPD} vls_ser_e;

  typedef struct packed {
    logic [1:0] pdn_s;
    logic [1:0] pclk_s;
    logic pclk_p;
    logic [PIX_BITS-1:0] pix_s1;
    logic [PIX_BITS-1:0] pix_s2;
    logic [1:0] awake_s;
    logic [1:0] back_s;
    logic [1:0] lrs_s;
    logic [1:0] strap_s;
    logic [7:0] cfg;
    logic crc_err;
    logic [31:0] rdata;
    logic hready;
    logic rd_pend;
    logic wr_pend;
    logic [1:0] sel;
    vls_ser_e st;
    logic lrs;
    logic leg_strap;
    logic [7:0] lock_cnt;
    logic [7:0] per_cnt;
    logic rate_err;
    logic [2:0] ctl;
    logic [2:0][1:0] stab;
    logic [7:0] win;
    logic [1:0][1:0] trn;
    logic [7:0] fs_age;
    logic [PIX_BITS-1:0] hold;
    logic hold_v;
    logic [SYM_BITS-1:0] sh;
    logic [5:0] bidx;
    logic busy;
    logic [15:0] scnt;
    logic [3:0] ldc;
    logic div;
    logic fwd;
    logic sent_one;
    logic [7:0] bf;
    logic [2:0] bbit;
    logic [2:0] fidx;
    logic [7:0] nonce;
    logic [3:0] good;
    logic [3:0] gpio;
    logic ctl_rx;
  } vls_ser_s;

  vls_ser_s q;
  vls_ser_s d;

  always_comb
  begin
    logic pe;
    logic tick;
    logic leg_act;
    logic ok;
    logic crc_set;
    logic [2:0] raw;
    logic [31:0] p;
    logic [31:0] ks;
    logic [31:0] sc;
    logic [25:0] lp;
    logic [SYM_BITS-1:0] word;
    logic [5:0] len;
    logic [7:0] fr;
    logic [15:0] per;
    pe = 1'b0;
    tick = 1'b0;
    ok = 1'b0;
    crc_set = 1'b0;
    raw = 3'h0;
    p = 32'h0;
    ks = 32'h0;
    sc = 32'h0;
    lp = 26'h0;
    word = '0;
    fr = 8'h00;
    per = {8'h00, q.per_cnt};
    d = q;
    leg_act = q.leg_strap | q.cfg[CFG_LEG]; // RQ13
    len = leg_act ? 6'(LEG_BITS) : 6'(SYM_BITS); // RQ11

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    d.pdn_s = {q.pdn_s[0], power_down_n};
    d.pclk_s = {q.pclk_s[0], pclk};
    d.pclk_p = q.pclk_s[1];
    d.pix_s1 = {ctl_tx, audio, frame_sync, line_sync, data_enable, colour};
    d.pix_s2 = q.pix_s1;
    d.awake_s = {q.awake_s[0], lnk.far_awake};
    d.back_s = {q.back_s[0], lnk.slow_return_channel};
    d.lrs_s = {q.lrs_s[0], low_rate_select};
    d.strap_s = {q.strap_s[0], legacy_strap};
    // rising or falling edge as configured
    pe = q.cfg[CFG_RISE] ? (q.pclk_s[1] & ~q.pclk_p) : (~q.pclk_s[1] & q.pclk_p); // RQ24

    // ----------------------------------------------------------------
    // register bus, reads take one wait state
    // ----------------------------------------------------------------
    d.rd_pend = 1'b0;
    d.wr_pend = 1'b0;
    d.hready = 1'b1;
    if (q.rd_pend)
    begin
      d.rdata = 32'h0;
      if (q.sel == 2'h1)
      begin
        d.rdata[7:0] = q.cfg;
      end
      else if (q.sel == 2'h2)
      begin
        d.rdata[STB_LOCK] = (q.st == S_LOCKED);
        d.rdata[STB_RPD] = (q.st == S_RPD);
        d.rdata[STB_LEG] = leg_act;
        d.rdata[STB_RATE] = q.rate_err;
        d.rdata[STB_CRC] = q.crc_err;
        d.rdata[STB_NONCE] = (q.good == NONCE_GOOD);
        d.rdata[STB_GPIO +: GPIO_BITS] = q.gpio;
      end
    end
    if (q.wr_pend && q.sel == 2'h1)
    begin
      d.cfg = hwdata[7:0]; // RQ21
    end
    if (q.wr_pend && q.sel == 2'h2 && hwdata[STB_CRC])
    begin
      d.crc_err = 1'b0;
    end
    if (hsel && htrans[1] && hready)
    begin
      d.sel = (haddr == CFG_ADDR) ? 2'h1 : ((haddr == STAT_ADDR) ? 2'h2 : 2'h0);
      d.wr_pend = hwrite;
      d.rd_pend = ~hwrite;
      d.hready = hwrite;
    end

    // ----------------------------------------------------------------
    // power state
    // ----------------------------------------------------------------
    if (!q.pdn_s[1])
    begin
      d.st = S_OFF; // RQ18
    end
    else
    begin
      unique case (q.st)
        S_OFF:
        begin
          // straps only take effect across a power-down cycle
          d.lrs = q.lrs_s[1]; // RQ23
          d.leg_strap = q.strap_s[1];
          d.lock_cnt = 8'h00;
          d.st = S_LOCKING;
        end
        S_LOCKING:
        begin
          if (pe)
          begin
            d.lock_cnt = q.lock_cnt + 8'h01;
          end
          if (pe && q.lock_cnt == LOCK_PCLKS - 8'h01)
          begin
            d.st = S_LOCKED; // RQ5
            d.scnt = 16'h0000;
            d.busy = 1'b0;
            d.hold_v = 1'b0;
            d.sent_one = 1'b0;
            d.bbit = 3'h0;
            d.fidx = 3'h0;
            d.good = 4'h0;
          end
        end
        S_LOCKED:
        begin
        end
        S_RPD:
        begin
          if (q.awake_s[1])
          begin
            d.lock_cnt = 8'h00;
            d.st = S_LOCKING; // RQ20
          end
        end
      endcase
      if ((q.st == S_LOCKING || q.st == S_LOCKED) && q.cfg[CFG_RAPD] && !q.awake_s[1])
      begin
        d.st = S_RPD; // RQ19
      end
    end

    // ----------------------------------------------------------------
    // pixel period check
    // ----------------------------------------------------------------
    d.per_cnt = (q.per_cnt == 8'hff) ? q.per_cnt : q.per_cnt + 8'h01;
    if (pe)
    begin
      d.per_cnt = 8'h01;
      if (q.lrs)
      begin
        d.rate_err = (per * PCLK_MIN_MHZ > CLK_MHZ) || (per * PCLK_LF_MHZ <= CLK_MHZ); // RQ22
      end
      else
      begin
        d.rate_err = (per * PCLK_LF_MHZ > CLK_MHZ) // RQ2
          || (per * (leg_act ? PCLK_LEG_MAX_MHZ : PCLK_MAX_MHZ) < CLK_MHZ); // RQ12
      end
    end

    // ----------------------------------------------------------------
    // control signal filter and capture
    // ----------------------------------------------------------------
    if (pe && q.st == S_LOCKED)
    begin
      raw = q.pix_s2[26:24];
      d.win = q.win + 8'h01;
      if (q.win == CTL_WINDOW - 8'h01)
      begin
        d.win = 8'h00;
        d.trn = '0;
      end
      d.fs_age = (q.fs_age == 8'hff) ? q.fs_age : q.fs_age + 8'h01;
      for (int i = 0; i < 3; i++)
      begin
        if (raw[i] != q.ctl[i])
        begin
          d.stab[i] = (q.stab[i] == FILT_PCLKS) ? q.stab[i] : q.stab[i] + 2'h1;
          ok = !q.cfg[CFG_FILT] || d.stab[i] == FILT_PCLKS; // RQ14 RQ15 RQ17
          if (i < 2)
          begin
            ok = ok && q.trn[i] < DEHS_TRANS; // RQ14 RQ15
          end
          else
          begin
            ok = ok && q.fs_age >= FS_MIN_PCLKS - 8'h01; // RQ16
          end
          if (ok)
          begin
            d.ctl[i] = raw[i];
            d.stab[i] = 2'h0;
            if (i < 2)
            begin
              d.trn[i] = d.trn[i] + 2'h1;
            end
            else
            begin
              d.fs_age = 8'h00;
            end
          end
        end
        else
        begin
          d.stab[i] = 2'h0;
        end
      end
      // newest pixel wins if the line is still busy
      d.hold = {q.pix_s2[30:27], d.ctl, q.pix_s2[23:0]}; // RQ24
      d.hold_v = 1'b1;
    end

    // ----------------------------------------------------------------
    // link clock divider and symbol shifter
    // ----------------------------------------------------------------
    if (q.st == S_LOCKED)
    begin
      d.ldc = q.ldc + 4'h1;
      if (q.ldc == 4'(LINK_HALF - 1)) // RQ3
      begin
        d.ldc = 4'h0;
        d.div = ~q.div;
        tick = q.div;
      end
    end
    else
    begin
      d.ldc = 4'h0;
      d.div = 1'b0;
      d.fwd = 1'b0;
    end
    if (tick && q.busy)
    begin
      d.fwd = q.sh[0]; // RQ4
      d.sh = q.sh >> 1;
      d.bidx = q.bidx + 6'h01;
      // a legacy switch mid-symbol ends the symbol early instead of running on
      if (q.bidx >= len - 6'h01)
      begin
        d.busy = 1'b0;
        if (q.sent_one)
        begin
          fr = {q.back_s[1], q.bf[7:1]}; // RQ10
          d.bf = fr;
          d.bbit = q.bbit + 3'h1;
          if (q.bbit == 3'h7)
          begin
            d.fidx = q.fidx + 3'h1;
            if (fr[0] && !(^fr[7:1]))
            begin
              d.gpio = fr[4:1]; // RQ9
              d.ctl_rx = fr[6];
              d.nonce[q.fidx] = fr[5]; // RQ8
              d.good = (q.good == NONCE_GOOD) ? q.good : q.good + 4'h1;
            end
            // far end going down zeroes the line, that is no frame error
            else if (q.awake_s[1])
            begin
              crc_set = 1'b1;
              d.good = 4'h0;
            end
          end
        end
        d.sent_one = 1'b1;
      end
    end
    else if (tick && q.hold_v)
    begin
      p = {1'b0, q.hold};
      if (q.cfg[CFG_CIPH] && q.good == NONCE_GOOD)
      begin
        ks = mix(KEY ^ {4{q.nonce}}, q.scnt); // RQ8
        p[23:0] = p[23:0] ^ ks[23:0]; // RQ7
        p[29:27] = p[29:27] ^ ks[29:27];
        p[31] = 1'b1;
      end
      sc = mix(SCR_SEED, q.scnt);
      if (leg_act)
      begin
        lp = {q.hold[26:24], q.hold[23:1]} ^ sc[25:0]; // RQ11
        word = {7'h00, lp, 2'b01};
      end
      else
      begin
        p = p ^ sc; // RQ6
        if (ones(p) > 6'h10)
        begin
          word = {~p, 3'b101}; // RQ6
        end
        else
        begin
          word = {p, 3'b001}; // RQ1
        end
      end
      d.fwd = word[0];
      d.sh = word >> 1;
      d.bidx = 6'h01;
      d.busy = 1'b1;
      d.hold_v = 1'b0;
      d.scnt = q.scnt + 16'h0001;
    end
    else if (tick)
    begin
      d.fwd = 1'b0;
    end
    // set wins over a clear in the same cycle
    d.crc_err = d.crc_err | crc_set; // RQ9
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.hready <= 1'b1;
      q.st <= S_OFF;
    end
    else
    begin
      q <= d;
    end
  end

  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign ctl_rx = q.ctl_rx;
  assign lnk.link_clk = q.div;
  assign lnk.fast_forward_channel = q.fwd;

endmodule

// ==== pkg/vls_pkg.sv ====
package vls_pkg;

  // ----------------------------------------------------------------
  // symbol and channel layout
  // ----------------------------------------------------------------
  localparam int SYM_BITS = 35;
  localparam int LEG_BITS = 28;
  localparam int BACK_BITS = 8;
  localparam int GPIO_BITS = 4;
  localparam int NONCE_BITS = 8;
  localparam int PIX_BITS = 31;

  // line rates in Mbps, one symbol per pixel cycle
  localparam int LINE_MIN_MBPS = 525;
  localparam int LINE_MAX_MBPS = 2975;
  localparam int PAY_MIN_MBPS = 175;
  localparam int LEG_LINE_MIN_MBPS = 140;
  localparam int LEG_LINE_MAX_MBPS = 1820;

  // ----------------------------------------------------------------
  // timing counts, in pixel cycles except DEHS_TRANS, a transition count, and LINK_HALF_DEF, which is in clk cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] LOCK_PCLKS = 8'h83;
  localparam logic [7:0] CTL_WINDOW = 8'h82;
  localparam logic [7:0] FS_MIN_PCLKS = 8'h82;
  localparam logic [1:0] DEHS_TRANS = 2'h2;
  localparam logic [1:0] FILT_PCLKS = 2'h3;
  localparam int LINK_HALF_DEF = 1;

  // pixel clock range check, frequencies in MHz against clk
  localparam logic [15:0] CLK_MHZ = 16'h007d;
  localparam logic [15:0] PCLK_MIN_MHZ = 16'h0005;
  localparam logic [15:0] PCLK_LF_MHZ = 16'h000f;
  localparam logic [15:0] PCLK_LEG_MAX_MHZ = 16'h0041;
  localparam logic [15:0] PCLK_MAX_MHZ = 16'h0055;

  // ----------------------------------------------------------------
  // register map: index, byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_IDX = 8'h01;
  localparam logic [7:0] STAT_IDX = 8'h0c;
  localparam logic [31:0] CFG_ADDR = {22'h0, CFG_IDX, 2'h0};
  localparam logic [31:0] STAT_ADDR = {22'h0, STAT_IDX, 2'h0};
  localparam int CFG_FILT = 0;
  localparam int CFG_LEG = 1;
  localparam int CFG_RISE = 2;
  localparam int CFG_CIPH = 3;
  localparam int CFG_RAPD = 7;
  localparam logic [7:0] CFG_RST = 8'h05;
  localparam int STB_LOCK = 0;
  localparam int STB_RPD = 1;
  localparam int STB_LEG = 2;
  localparam int STB_RATE = 3;
  localparam int STB_CRC = 4;
  localparam int STB_NONCE = 5;
  localparam int STB_GPIO = 8;

  // ----------------------------------------------------------------
  // stream seeds, arbitrary values
  // ----------------------------------------------------------------
  localparam logic [31:0] SCR_SEED = 32'h9e3779b9;
  localparam logic [31:0] KEY_DEFAULT = 32'h1234abcd;
  localparam logic [7:0] NONCE_DEFAULT = 8'h5a;
  localparam logic [3:0] NONCE_GOOD = 4'h8;

  // keyed by symbol count so both ends need no shared running state
  function automatic logic [31:0] mix(input logic [31:0] seed, input logic [15:0] cnt);
    logic [31:0] x;
    x = seed ^ {cnt, ~cnt};
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  function automatic logic [5:0] ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++)
    begin
      n = n + 6'(v[i]);
    end
    return n;
  endfunction

endpackage

// ==== pkg/vls_link_if.sv ====
`timescale 1ns/100ps
interface vls_link_if;
  logic link_clk;
  logic fast_forward_channel;
  logic slow_return_channel;
  logic far_awake;

  modport ser (
    output link_clk,
    output fast_forward_channel,
    input slow_return_channel,
    input far_awake
  );

  modport des (
    input link_clk,
    input fast_forward_channel,
    output slow_return_channel,
    output far_awake
  );
endinterface

// ==== rtl/vls_deserializer.sv ====
`timescale 1ns/100ps
module vls_deserializer #(
  parameter logic [31:0] KEY = vls_pkg::KEY_DEFAULT,
  parameter logic [7:0] NONCE = vls_pkg::NONCE_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // user side
  input wire logic power_down_n,
  input wire logic legacy_mode,
  input wire logic [3:0] gpio_tx,
  input wire logic ctl_tx,
  output logic [23:0] colour,
  output logic data_enable,
  output logic line_sync,
  output logic frame_sync,
  output logic [2:0] audio,
  output logic ctl_rx,
  output logic sym_strobe,
  output logic locked,
  // link
  vls_link_if.des lnk
);
  import vls_pkg::*;

  typedef struct packed {
    logic [1:0] pdn_s;
    logic [1:0] lclk_s;
    logic lclk_p;
    logic [1:0] fwd_s;
    logic rx;
    logic [5:0] cnt;
    logic [SYM_BITS-1:0] sh;
    logic [15:0] scnt;
    logic [2:0] bbit;
    logic [2:0] fidx;
    logic [7:0] bf;
    logic back;
    logic awake;
    logic [23:0] colour;
    logic [2:0] ctl;
    logic [2:0] aud;
    logic ctl_rx;
    logic strobe;
    logic locked;
  } vls_des_s;

  vls_des_s q;
  vls_des_s d;

  always_comb
  begin
    logic [5:0] len;
    logic [SYM_BITS-1:0] sh;
    logic [SYM_BITS-1:0] w;
    logic [31:0] p;
    logic [31:0] sc;
    logic [31:0] ks;
    logic [25:0] lp;
    logic [7:0] fr;
    d = q;
    len = legacy_mode ? 6'(LEG_BITS) : 6'(SYM_BITS);
    sh = {q.fwd_s[1], q.sh[SYM_BITS-1:1]};
    w = legacy_mode ? (sh >> (SYM_BITS - LEG_BITS)) : sh;
    sc = mix(SCR_SEED, q.scnt);
    ks = mix(KEY ^ {4{NONCE}}, q.scnt);
    p = w[SYM_BITS-1:3] ^ {32{w[2]}};
    p = p ^ sc;
    lp = w[27:2] ^ sc[25:0];
    fr = {^{ctl_tx, NONCE[q.fidx], gpio_tx}, ctl_tx, NONCE[q.fidx], gpio_tx, 1'b1};
    d.pdn_s = {q.pdn_s[0], power_down_n};
    d.lclk_s = {q.lclk_s[0], lnk.link_clk};
    d.lclk_p = q.lclk_s[1];
    d.fwd_s = {q.fwd_s[0], lnk.fast_forward_channel};
    d.awake = q.pdn_s[1];
    d.strobe = 1'b0;
    if (!q.pdn_s[1])
    begin
      d.rx = 1'b0;
      d.scnt = 16'h0000;
      d.bbit = 3'h0;
      d.fidx = 3'h0;
      d.back = 1'b0;
      d.locked = 1'b0;
    end
    else if (q.lclk_s[1] && !q.lclk_p)
    begin
      d.sh = sh;
      d.cnt = q.cnt + 6'h01;
      if (!q.rx)
      begin
        // idle line is low, a symbol opens with a one
        d.rx = q.fwd_s[1];
        d.cnt = 6'h01;
      end
      else if (q.cnt == len - 6'h01)
      begin
        d.rx = 1'b0;
        if (!w[1])
        begin
          if (legacy_mode)
          begin
            d.colour = {lp[22:0], 1'b0};
            d.ctl = lp[25:23];
            d.aud = 3'h0;
          end
          else
          begin
            if (p[31])
            begin
              p[23:0] = p[23:0] ^ ks[23:0];
              p[29:27] = p[29:27] ^ ks[29:27];
            end
            d.colour = p[23:0];
            d.ctl = p[26:24];
            d.aud = p[29:27];
            d.ctl_rx = p[30];
          end
          d.strobe = 1'b1;
          d.locked = 1'b1;
          d.scnt = q.scnt + 16'h0001;
          // one return bit per received symbol
          d.back = (q.bbit == 3'h0) ? fr[0] : q.bf[q.bbit];
          if (q.bbit == 3'h0)
          begin
            d.bf = fr;
          end
          d.bbit = q.bbit + 3'h1;
          if (q.bbit == 3'h7)
          begin
            d.fidx = q.fidx + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign colour = q.colour;
  assign data_enable = q.ctl[0];
  assign line_sync = q.ctl[1];
  assign frame_sync = q.ctl[2];
  assign audio = q.aud;
  assign ctl_rx = q.ctl_rx;
  assign sym_strobe = q.strobe;
  assign locked = q.locked;
  assign lnk.slow_return_channel = q.back;
  assign lnk.far_awake = q.awake;

endmodule

// ==== sim/vls_link_asserts.sv ====
`timescale 1ns/100ps
module vls_link_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link wires
  input wire logic link_clk,
  input wire logic fast_forward_channel,
  input wire logic slow_return_channel,
  input wire logic far_awake
);
  // ----
  // wire checks
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  half_period_a: assert property ($rose(link_clk) |=> $fell(link_clk))
    else $error("link clock high too long");
  bit_hold_a: assert property (link_clk |-> $stable(fast_forward_channel))
    else $error("forward bit moved while link clock high");
  // a forced idle on remote power-down may cut a bit short
  bit_width_a: assert property ($changed(fast_forward_channel) && far_awake |=> $stable(fast_forward_channel))
    else $error("forward bit shorter than a link period");
  ret_hold_a: assert property ($changed(slow_return_channel) && far_awake |=>
    ($stable(slow_return_channel) || !far_awake) [*8])
    else $error("return bit changed twice in one symbol");
  rpd_stop_a: assert property ($fell(far_awake) |-> ##[1:60] !link_clk [*4])
    else $error("link kept running with far end down");
  relock_wait_a: assert property ($rose(far_awake) |-> !link_clk [*8])
    else $error("link restarted without lock time");
  down_quiet_a: assert property (!far_awake [*8] |-> !link_clk)
    else $error("link clock runs while far end down");
  down_return_a: assert property (!far_awake [*4] |-> !slow_return_channel)
    else $error("return bit set while far end down");
endmodule

// ==== sim/vls_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module vls_tb_top;
  import vls_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, cfg_v;
  logic hreadyout, hresp, ser_ctl_rx, des_ctl_rx, sym_strobe, locked, rx_de, rx_hs, rx_vs;
  logic pclk = 1'b0;
  logic de = 1'b0;
  logic ser_pdn = 1'b0;
  logic des_pdn = 1'b0;
  logic leg = 1'b0;
  logic ctl_s = 1'b0;
  logic ctl_d = 1'b0;
  logic [23:0] colour = 24'h0;
  logic [23:0] rx_colour;
  logic [2:0] audio = 3'h0;
  logic [2:0] rx_audio;
  logic [3:0] gpio = 4'h0;
  logic [6:0] div = 7'h0;
  int pix_cnt = 0;
  int cyc = 0;
  int fail_count = 0;
  int checks_done = 0;
  int t0;

  always #4 clk = ~clk;

  vls_link_if lnk_i ();
  vls_serializer u_vls_serializer (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pclk(pclk), .colour(colour), .data_enable(de), .line_sync(de), .frame_sync(1'b0),
    .audio(audio), .ctl_tx(ctl_s), .power_down_n(ser_pdn), .low_rate_select(1'b0), .legacy_strap(1'b0),
    .ctl_rx(ser_ctl_rx), .lnk(lnk_i));
  vls_deserializer u_vls_deserializer (.clk(clk), .resetn(resetn), .power_down_n(des_pdn),
    .legacy_mode(leg), .gpio_tx(gpio), .ctl_tx(ctl_d), .colour(rx_colour), .data_enable(rx_de),
    .line_sync(rx_hs), .frame_sync(rx_vs), .audio(rx_audio), .ctl_rx(des_ctl_rx), .sym_strobe(sym_strobe),
    .locked(locked), .lnk(lnk_i));
  vls_link_asserts u_vls_link_asserts (.clk(clk), .resetn(resetn), .link_clk(lnk_i.link_clk),
    .fast_forward_channel(lnk_i.fast_forward_channel), .slow_return_channel(lnk_i.slow_return_channel),
    .far_awake(lnk_i.far_awake));

  // ----
  // pixel clock and timeout
  // ----
  // 84 clk pixel period leaves room for a whole symbol per pixel
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    div <= (div == 7'h29) ? 7'h00 : div + 7'h01;
    if (div == 7'h29)
    begin
      pclk <= ~pclk;
      pix_cnt <= pix_cnt + int'(!pclk);
    end
    if (cyc == 90000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  // ----
  // tasks
  // ----
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic strobes(input int n);
    repeat (n)
    begin
      @(posedge clk);
      while (sym_strobe !== 1'b1) @(posedge clk);
    end
  endtask

  function automatic logic [31:0] stat_exp(input logic rpd, input logic [3:0] g);
    stat_exp = 32'h0;
    stat_exp[STB_LOCK] = !rpd;
    stat_exp[STB_RPD] = rpd;
    stat_exp[STB_LEG] = leg;
    // bench pixel clock sits below the legal range on purpose
    stat_exp[STB_RATE] = 1'b1;
    stat_exp[STB_GPIO +: 4] = g;
  endfunction

  task automatic power_up(input logic both);
    @(posedge clk);
    if (both)
      ser_pdn <= 1'b1;
    des_pdn <= 1'b1;
    t0 = pix_cnt;
    while (lnk_i.link_clk !== 1'b1) @(posedge clk);
    `CHK("lock_time", 1'b1, (pix_cnt - t0 >= int'(LOCK_PCLKS)) && (pix_cnt - t0 <= int'(LOCK_PCLKS) + 2))
    while (locked !== 1'b1) @(posedge clk);
    strobes(2);
  endtask

  // return frames are 8 symbols long, so allow two of them
  task automatic pixel(input logic [23:0] c, input logic [2:0] a, input logic k, input logic [3:0] g, input logic dk);
    colour <= c;
    audio <= a;
    ctl_s <= k;
    gpio <= g;
    ctl_d <= dk;
    strobes(18);
    `CHK("colour", c, rx_colour)
    `CHK("audio", a, rx_audio)
    `CHK("ctl_fwd", k, des_ctl_rx)
    `CHK("ctl_back", dk, ser_ctl_rx)
    ahb(1'b0, STAT_ADDR, 32'h0);
    `CHK("status", stat_exp(1'b0, g), rd & 32'h00000f1f)
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    rd = $urandom(32'hb3c44093);
    cfg_v = {24'h0, CFG_RST} | (32'h1 << CFG_RAPD);
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    ahb(1'b0, CFG_ADDR, 32'h0);
    `CHK("cfg_reset", {24'h0, CFG_RST}, rd)
    ahb(1'b1, CFG_ADDR, cfg_v);
    ahb(1'b0, CFG_ADDR, 32'h0);
    `CHK("cfg_rapd", cfg_v, rd)
    ahb(1'b0, 32'h00000040, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    power_up(1'b1);
    pixel(24'hffffff, 3'h7, 1'b1, 4'hf, 1'b1);
    pixel(24'h000000, 3'h0, 1'b0, 4'h0, 1'b0);
    repeat (4) pixel(24'($urandom), 3'($urandom), 1'($urandom), 4'($urandom), 1'($urandom));
    // nonce is complete by now, so the next pixel travels enciphered
    ahb(1'b1, CFG_ADDR, cfg_v | (32'h1 << CFG_CIPH));
    pixel(24'($urandom), 3'($urandom), 1'($urandom), 4'($urandom), 1'($urandom));
    @(posedge pclk);
    de <= 1'b1;
    @(posedge pclk);
    de <= 1'b0;
    strobes(4);
    `CHK("glitch", 1'b0, rx_de)
    de <= 1'b1;
    strobes(6);
    `CHK("de_pass", 1'b1, rx_de)
    `CHK("hs_pass", 1'b1, rx_hs)
    des_pdn <= 1'b0;
    repeat (20) @(posedge clk);
    ahb(1'b0, STAT_ADDR, 32'h0);
    `CHK("rpd", 1'b1, rd[STB_RPD])
    `CHK("nonce", 1'b1, rd[STB_NONCE])
    power_up(1'b0);
    pixel(24'($urandom), 3'($urandom), 1'b1, 4'($urandom), 1'($urandom));
    // switch to legacy while the link is stopped so both symbol counts restart together
    des_pdn <= 1'b0;
    repeat (20) @(posedge clk);
    ahb(1'b1, CFG_ADDR, cfg_v | (32'h1 << CFG_LEG));
    leg <= 1'b1;
    power_up(1'b0);
    // legacy drops colour bit 0, audio and the forward control bit
    pixel(24'($urandom) & 24'hfffffe, 3'h0, 1'b1, 4'($urandom), 1'($urandom));
    ahb(1'b0, STAT_ADDR, 32'h0);
    `CHK("legacy", 1'b1, rd[STB_LEG])
    print_verdict();
  end
endmodule
